// ---- hw/dcs_params.svh ----
// register offsets, field positions and reset values of the display clock block
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// byte offsets
`define DCS_SRC_SEL_OFS 5'h00
`define DCS_DIV_EN_OFS 5'h04
`define DCS_PTC_OFS 5'h08
`define DCS_PIX_DIV_OFS 5'h0c
`define DCS_STATUS_OFS 5'h10

// clock_source_select_reg fields
`define DCS_U0_SEL_BIT 0
`define DCS_U1_SEL_BIT 1

// clock_divider_enable_reg fields, divisor is field value plus one
`define DCS_U0_DIV_LSB 0
`define DCS_U0_EN_BIT 3
`define DCS_U1_DIV_LSB 4
`define DCS_U1_EN_BIT 7

// panel_timing_control_reg fields
`define DCS_SKIP_BIT 0
`define DCS_NARROW_BIT 1

// pixel divider register fields
`define DCS_U0_PIX_LSB 0
`define DCS_U1_PIX_LSB 8

// status register fields
`define DCS_U0_RUN_BIT 0
`define DCS_U1_RUN_BIT 1
`define DCS_U0_ASRC_BIT 2
`define DCS_U1_ASRC_BIT 3

// reset values
`define DCS_SRC_SEL_RST 2'h0
`define DCS_DIV_RST 3'h0
`define DCS_EN_RST 1'h0
`define DCS_SKIP_RST 1'h0
`define DCS_NARROW_RST 1'h0
`define DCS_PIX_DIV_RST 8'h00

// nominal source rates in mhz, for reference by software models
`define DCS_SRC_A_MHZ 452
`define DCS_SRC_B_MHZ 480

`endif

// ---- hw/dcs_pkg.sv ----
// types shared by the display clock block
// assumes dcs_params.svh for all numeric constants
package dcs_pkg;
  // which high-frequency source feeds an instance
  typedef enum logic {
    DCS_SRC_A = 1'b0,
    DCS_SRC_B = 1'b1
  } dcs_src_t;
  // predivider code, divisor is code plus one (1..8)
  typedef logic [2:0] dcs_div_t;
  typedef logic [31:0] dcs_word_t;
endpackage

// ---- hw/dcs_prediv.sv ----
// source selection, 1..8 predivider and gate for one display controller instance
// assumes source ticks are one-cycle pulses made on sys_clk, one per source clock edge
`timescale 1ns/100ps
`include "dcs_params.svh"
module dcs_prediv (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic src_a_tick,
  input wire logic src_b_tick,
  input wire dcs_pkg::dcs_src_t sel,
  input wire dcs_pkg::dcs_div_t div,
  input wire logic en,
  output logic out_tick,
  output logic running,
  output dcs_pkg::dcs_src_t act_src
);
  import dcs_pkg::*;

  dcs_src_t act_sel_ff, nxt_act_sel;
  dcs_div_t act_div_ff, nxt_act_div;
  dcs_div_t cnt_ff, nxt_cnt;
  logic act_en_ff, nxt_act_en;
  logic tick_ff, nxt_tick;
  logic src_tick;
  logic wrap;

  assign src_tick = (act_sel_ff == DCS_SRC_B) ? src_b_tick : src_a_tick; // RULE1
  assign wrap = act_en_ff && src_tick && (cnt_ff == act_div_ff);

  // config is taken only while stopped or at a period end, so no short pulse
  always_comb begin
    nxt_act_sel = act_sel_ff;
    nxt_act_div = act_div_ff;
    nxt_act_en = act_en_ff;
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!act_en_ff || wrap) begin // RULE10
      nxt_act_sel = sel; // RULE4
      nxt_act_div = div; // RULE5
      nxt_act_en = en; // RULE6
      nxt_cnt = 3'h0;
      nxt_tick = wrap;
    end else if (src_tick) begin
      nxt_cnt = cnt_ff + 3'h1; // RULE2
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_sel_ff <= DCS_SRC_A;
      act_div_ff <= `DCS_DIV_RST;
      act_en_ff <= `DCS_EN_RST;
      cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else begin
      act_sel_ff <= nxt_act_sel;
      act_div_ff <= nxt_act_div;
      act_en_ff <= nxt_act_en;
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign out_tick = tick_ff;
  assign running = act_en_ff;
  assign act_src = act_sel_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  cnt_in_range_a: assert property (cnt_ff <= act_div_ff) else $error("predivider count beyond divisor"); // RULE2
  cfg_at_boundary_a: assert property ($changed(act_div_ff) |-> $past(wrap) || !$past(act_en_ff)) // RULE10
    else $error("divisor changed mid period");
  tick_when_on_a: assert property (tick_ff |-> $past(act_en_ff) && $past(src_tick))
    else $error("clock pulse while gated"); // RULE6
endmodule // dcs_prediv

// ---- hw/dcs_pixdiv.sv ----
// second integer division inside a display controller, predivided ticks to pixel ticks
// assumes in_tick is a one-cycle pulse on sys_clk
`timescale 1ns/100ps
module dcs_pixdiv #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_tick,
  input wire logic [W-1:0] div,
  output logic pix_tick
);
  if (W < 1 || W > 16) begin : g_chk
    $error("dcs_pixdiv width out of range");
  end

  logic [W-1:0] cnt_ff, nxt_cnt;
  logic [W-1:0] act_div_ff, nxt_act_div;
  logic tick_ff, nxt_tick;
  logic wrap;

  assign wrap = in_tick && (cnt_ff == act_div_ff);

  // divisor reloaded only at a pixel period end to keep whole periods
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_act_div = act_div_ff;
    nxt_tick = 1'b0;
    if (wrap) begin // RULE3
      nxt_cnt = '0;
      nxt_act_div = div;
      nxt_tick = 1'b1;
    end else if (in_tick) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      act_div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      act_div_ff <= nxt_act_div;
      tick_ff <= nxt_tick;
    end
  end

  assign pix_tick = tick_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  pix_cnt_range_a: assert property (cnt_ff <= act_div_ff) else $error("pixel count beyond divisor"); // RULE3
  pix_tick_cause_a: assert property (tick_ff |-> $past(in_tick)) else $error("pixel tick without input tick"); // RULE3
endmodule // dcs_pixdiv

// ---- hw/dcs_top.sv ----
// clock source, predivide and enable for two display controller instances,
// plus the panel timing controller path select and 18-bit panel data mapping
// assumes an avalon-mm master on sys_clk and source ticks made on sys_clk
//
// Behaviour
// RULE1: each instance picks source a or b
// RULE2: selected source divided by 1 through 8
// RULE3: controller divides again for pixel clock
// RULE4: separate source select bit per instance
// RULE5: separate predivider field per instance
// RULE6: own enable bit starts each instance
// RULE7: one write updates dividers and enables together
// RULE8: timing controller in path unless skipped
// RULE9: 18-bit panel takes six colour msbs
// RULE10: config changes never make short clock pulses
`timescale 1ns/100ps
`include "dcs_params.svh"
module dcs_top #(
  parameter int PIX_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire dcs_pkg::dcs_word_t avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output dcs_pkg::dcs_word_t avs_readdata,
  output logic avs_waitrequest,
  // source clocks as one-cycle edge ticks
  input wire logic source_clock_a_tick,
  input wire logic source_clock_b_tick,
  // predivided clocks to the two instances and their pixel clocks
  output logic unit0_clock_tick,
  output logic unit1_clock_tick,
  output logic unit0_pixel_tick,
  output logic unit1_pixel_tick,
  // display output path
  input wire logic [23:0] unit0_rgb,
  output logic panel_timing_active,
  output logic [23:0] panel_rgb
);
  import dcs_pkg::*;

  if (PIX_W < 1 || PIX_W > 8) begin : g_chk
    $error("dcs_top pixel divider width must be 1..8");
  end

  // software registers
  dcs_src_t u0_sel_ff, nxt_u0_sel;
  dcs_src_t u1_sel_ff, nxt_u1_sel;
  dcs_div_t u0_div_ff, nxt_u0_div;
  dcs_div_t u1_div_ff, nxt_u1_div;
  logic u0_en_ff, nxt_u0_en;
  logic u1_en_ff, nxt_u1_en;
  logic skip_ff, nxt_skip;
  logic narrow_ff, nxt_narrow;
  logic [PIX_W-1:0] u0_pix_ff, nxt_u0_pix;
  logic [PIX_W-1:0] u1_pix_ff, nxt_u1_pix;
  // bus response
  logic wait_ff, nxt_wait;
  dcs_word_t rdata_ff, nxt_rdata;
  // output path
  logic ptc_act_ff, nxt_ptc_act;
  logic [23:0] rgb_ff, nxt_rgb;
  // instance state
  logic u0_tick, u1_tick, u0_run, u1_run;
  dcs_src_t u0_asrc, u1_asrc;
  logic u0_pix, u1_pix;
  logic wr_ok, rd_ok;

  // expand byte enables to a bit mask
  function automatic dcs_word_t be_mask(input logic [3:0] be);
    dcs_word_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // merge a write under byte enables into an old word
  function automatic dcs_word_t be_merge(input dcs_word_t old_w, input dcs_word_t new_w, input logic [3:0] be);
    dcs_word_t m;
    m = be_mask(be);
    return (old_w & ~m) | (new_w & m);
  endfunction

  // request completes at the edge where waitrequest is seen low
  assign wr_ok = avs_write && !wait_ff;
  assign rd_ok = avs_read && !wait_ff;

  // waitrequest drops for one cycle, one cycle after a request appears
  always_comb begin
    nxt_wait = !((avs_read || avs_write) && wait_ff);
  end

  // register writes; one word carries both dividers and both enables
  always_comb begin
    dcs_word_t w;
    w = '0;
    nxt_u0_sel = u0_sel_ff;
    nxt_u1_sel = u1_sel_ff;
    nxt_u0_div = u0_div_ff;
    nxt_u1_div = u1_div_ff;
    nxt_u0_en = u0_en_ff;
    nxt_u1_en = u1_en_ff;
    nxt_skip = skip_ff;
    nxt_narrow = narrow_ff;
    nxt_u0_pix = u0_pix_ff;
    nxt_u1_pix = u1_pix_ff;
    if (wr_ok) begin
      unique case (avs_address)
        `DCS_SRC_SEL_OFS: begin
          w = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
          if (avs_byteenable[0]) begin
            nxt_u0_sel = dcs_src_t'(w[`DCS_U0_SEL_BIT]); // RULE4
            nxt_u1_sel = dcs_src_t'(w[`DCS_U1_SEL_BIT]); // RULE4
          end
        end
        `DCS_DIV_EN_OFS: begin
          if (avs_byteenable[0]) begin
            nxt_u0_div = avs_writedata[`DCS_U0_DIV_LSB +: 3]; // RULE7
            nxt_u0_en = avs_writedata[`DCS_U0_EN_BIT]; // RULE7
            nxt_u1_div = avs_writedata[`DCS_U1_DIV_LSB +: 3]; // RULE7
            nxt_u1_en = avs_writedata[`DCS_U1_EN_BIT]; // RULE7
          end
        end
        `DCS_PTC_OFS: begin
          if (avs_byteenable[0]) begin
            nxt_skip = avs_writedata[`DCS_SKIP_BIT]; // RULE8
            nxt_narrow = avs_writedata[`DCS_NARROW_BIT];
          end
        end
        `DCS_PIX_DIV_OFS: begin
          w = be_merge({16'h0000, 8'(u1_pix_ff), 8'(u0_pix_ff)}, avs_writedata, avs_byteenable);
          nxt_u0_pix = w[`DCS_U0_PIX_LSB +: PIX_W]; // RULE3
          nxt_u1_pix = w[`DCS_U1_PIX_LSB +: PIX_W]; // RULE3
        end
        default: begin
          // status and unmapped offsets ignore writes
        end
      endcase
    end
  end

  // read data captured one cycle before the completing edge
  always_comb begin
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff) begin
      nxt_rdata = '0;
      unique case (avs_address)
        `DCS_SRC_SEL_OFS: begin
          nxt_rdata[`DCS_U0_SEL_BIT] = u0_sel_ff;
          nxt_rdata[`DCS_U1_SEL_BIT] = u1_sel_ff;
        end
        `DCS_DIV_EN_OFS: begin
          nxt_rdata[`DCS_U0_DIV_LSB +: 3] = u0_div_ff;
          nxt_rdata[`DCS_U0_EN_BIT] = u0_en_ff;
          nxt_rdata[`DCS_U1_DIV_LSB +: 3] = u1_div_ff;
          nxt_rdata[`DCS_U1_EN_BIT] = u1_en_ff;
        end
        `DCS_PTC_OFS: begin
          nxt_rdata[`DCS_SKIP_BIT] = skip_ff;
          nxt_rdata[`DCS_NARROW_BIT] = narrow_ff;
        end
        `DCS_PIX_DIV_OFS: begin
          nxt_rdata[`DCS_U0_PIX_LSB +: PIX_W] = u0_pix_ff;
          nxt_rdata[`DCS_U1_PIX_LSB +: PIX_W] = u1_pix_ff;
        end
        `DCS_STATUS_OFS: begin
          // shows what the gates really run, which lags the written enable
          nxt_rdata[`DCS_U0_RUN_BIT] = u0_run; // RULE6
          nxt_rdata[`DCS_U1_RUN_BIT] = u1_run; // RULE6
          nxt_rdata[`DCS_U0_ASRC_BIT] = u0_asrc;
          nxt_rdata[`DCS_U1_ASRC_BIT] = u1_asrc;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // output path: timing controller active out of reset, msbs kept for narrow panels
  always_comb begin
    nxt_ptc_act = !skip_ff; // RULE8
    nxt_rgb = unit0_rgb;
    if (narrow_ff) begin
      // six msbs of each colour land on the low panel lines; colour lsbs dropped
      nxt_rgb = {6'h00, unit0_rgb[23:18], unit0_rgb[15:10], unit0_rgb[7:2]}; // RULE9
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      u0_sel_ff <= DCS_SRC_A;
      u1_sel_ff <= DCS_SRC_A;
      u0_div_ff <= `DCS_DIV_RST;
      u1_div_ff <= `DCS_DIV_RST;
      u0_en_ff <= `DCS_EN_RST;
      u1_en_ff <= `DCS_EN_RST;
      skip_ff <= `DCS_SKIP_RST;
      narrow_ff <= `DCS_NARROW_RST;
      u0_pix_ff <= PIX_W'(`DCS_PIX_DIV_RST);
      u1_pix_ff <= PIX_W'(`DCS_PIX_DIV_RST);
      wait_ff <= 1'b1;
      rdata_ff <= '0;
      ptc_act_ff <= 1'b1;
      rgb_ff <= 24'h00_0000;
    end else begin
      u0_sel_ff <= nxt_u0_sel;
      u1_sel_ff <= nxt_u1_sel;
      u0_div_ff <= nxt_u0_div;
      u1_div_ff <= nxt_u1_div;
      u0_en_ff <= nxt_u0_en;
      u1_en_ff <= nxt_u1_en;
      skip_ff <= nxt_skip;
      narrow_ff <= nxt_narrow;
      u0_pix_ff <= nxt_u0_pix;
      u1_pix_ff <= nxt_u1_pix;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      ptc_act_ff <= nxt_ptc_act;
      rgb_ff <= nxt_rgb;
    end
  end

  // one predivider and gate per instance, each with its own select, divider, enable
  dcs_prediv u_pre0 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .src_a_tick(source_clock_a_tick),
    .src_b_tick(source_clock_b_tick),
    .sel(u0_sel_ff),
    .div(u0_div_ff),
    .en(u0_en_ff),
    .out_tick(u0_tick),
    .running(u0_run),
    .act_src(u0_asrc)
  );

  dcs_prediv u_pre1 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .src_a_tick(source_clock_a_tick),
    .src_b_tick(source_clock_b_tick),
    .sel(u1_sel_ff),
    .div(u1_div_ff),
    .en(u1_en_ff),
    .out_tick(u1_tick),
    .running(u1_run),
    .act_src(u1_asrc)
  );

  // second division stands in for the controller's own pixel divider
  dcs_pixdiv #(.W(PIX_W)) u_pix0 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_tick(u0_tick),
    .div(u0_pix_ff),
    .pix_tick(u0_pix)
  );

  dcs_pixdiv #(.W(PIX_W)) u_pix1 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_tick(u1_tick),
    .div(u1_pix_ff),
    .pix_tick(u1_pix)
  );

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign unit0_clock_tick = u0_tick;
  assign unit1_clock_tick = u1_tick;
  assign unit0_pixel_tick = u0_pix;
  assign unit1_pixel_tick = u1_pix;
  assign panel_timing_active = ptc_act_ff;
  assign panel_rgb = rgb_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence req_seen_s;
    (avs_read || avs_write) && wait_ff;
  endsequence
  sequence ack_then_idle_s;
    !wait_ff ##1 wait_ff;
  endsequence

  bus_ack_pulse_a: assert property (req_seen_s |=> ack_then_idle_s) else $error("waitrequest not a single low cycle");
  sel_write_a: assert property (wr_ok && avs_address == `DCS_SRC_SEL_OFS && avs_byteenable[0] // RULE4
    |=> u1_sel_ff == $past(avs_writedata[`DCS_U1_SEL_BIT])) else $error("source select not stored");
  div_en_write_a: assert property (wr_ok && avs_address == `DCS_DIV_EN_OFS && avs_byteenable[0] // RULE7
    |=> {u1_en_ff, u1_div_ff, u0_en_ff, u0_div_ff} == $past(avs_writedata[7:0]))
    else $error("divider word not stored whole");
  ptc_follow_a: assert property (panel_timing_active == !$past(skip_ff)) else $error("timing path select wrong"); // RULE8
  narrow_map_a: assert property ($past(narrow_ff) |-> panel_rgb[5:0] == $past(unit0_rgb[7:2])) // RULE9
    else $error("narrow panel mapping wrong");
  run_needs_en_a: assert property ($rose(u0_run) |-> $past(u0_en_ff)) else $error("instance started without enable"); // RULE6
endmodule // dcs_top

// ---- verification/dcs_unit_model.sv ----
// stand-in for one display controller consuming the predivided and pixel ticks
// assumes ticks are one-cycle pulses on sys_clk and an active-low async reset
`timescale 1ns/100ps
module dcs_unit_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_tick,
  input wire logic pix_tick,
  output logic [23:0] rgb,
  output int tick_cnt,
  output int pix_gap
);
  int since_ff;

  // count unit ticks overall and between pixel ticks; a coincident tick closes the window
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rgb <= 24'hc3a5f0;
      tick_cnt <= 0;
      pix_gap <= 0;
      since_ff <= 0;
    end else begin
      if (clk_tick) tick_cnt <= tick_cnt + 1;
      if (pix_tick) begin
        pix_gap <= since_ff + (clk_tick ? 1 : 0);
        since_ff <= 0;
        rgb <= rgb + 24'h0b1d35; // new pixel each pixel clock, held between pixel ticks
      end else if (clk_tick) begin
        since_ff <= since_ff + 1;
      end
    end
  end
endmodule // dcs_unit_model

// ---- verification/tb_dcs_top.sv ----
// self-checking bench for the display clock block over avalon-mm
// assumes source ticks every 3 (a) and 2 (b) sys_clk cycles, made here
`timescale 1ns/100ps
`include "dcs_params.svh"
module tb_dcs_top;
  import dcs_pkg::*;
  logic sys_clk, arst_n, avs_read, avs_write, a_tick, b_tick, avs_waitrequest, panel_timing_active;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [2:0] ph;
  logic [1:0] ck, px;
  logic [23:0] rgb0, panel_rgb;
  dcs_word_t avs_writedata, avs_readdata, rd;
  int tc [2];
  int pg [2];
  int num_errors = 0;
  int samples_checked = 0;
  int g;
  time t0;

  dcs_top #(.PIX_W(8)) u_dcs_top (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .source_clock_a_tick(a_tick), .source_clock_b_tick(b_tick), .unit0_clock_tick(ck[0]),
    .unit1_clock_tick(ck[1]), .unit0_pixel_tick(px[0]), .unit1_pixel_tick(px[1]),
    .unit0_rgb(rgb0), .panel_timing_active(panel_timing_active), .panel_rgb(panel_rgb));
  dcs_unit_model u_unit0_model (.sys_clk(sys_clk), .arst_n(arst_n), .clk_tick(ck[0]),
    .pix_tick(px[0]), .rgb(rgb0), .tick_cnt(tc[0]), .pix_gap(pg[0]));
  dcs_unit_model u_unit1_model (.sys_clk(sys_clk), .arst_n(arst_n), .clk_tick(ck[1]),
    .pix_tick(px[1]), .rgb(), .tick_cnt(tc[1]), .pix_gap(pg[1]));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // source ticks at fixed phase so every gap is exact
  always @(posedge sys_clk) begin
    ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
    a_tick <= (ph == 3'h0) || (ph == 3'h3);
    b_tick <= !ph[0];
  end

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cmp_w(input dcs_word_t got, input dcs_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_n(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one avalon access; held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input dcs_word_t d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) num_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk); // gap so strobes never toggle twice in one step
  endtask

  task wr(input logic [4:0] a, input dcs_word_t d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task rdc(input logic [4:0] a, input dcs_word_t exp);
    bus(1'b0, a, 32'h0, 4'hf);
    cmp_w(rd, exp);
  endtask

  // wait for n predivided ticks of one unit, bounded
  task tk(input int u, input int n);
    int k, w;
    k = 0;
    w = 0;
    while (k < n && w < 2000) begin
      @(posedge sys_clk);
      w++;
      if (ck[u] === 1'b1) k++;
    end
    if (w >= 2000) num_errors++;
  endtask

  task chk_gap(input int u, input int exp);
    tk(u, 1);
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (ck[u] !== 1'b1 && g < 2000);
    cmp_n(g, exp);
  endtask

  // watchdog, well above the roughly one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_sim;
  end

  initial begin
    arst_n = 1'b0;
    ph = 3'h0;
    a_tick = 1'b0;
    b_tick = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rdc(5'(i * 4), 32'h0);
    cmp_w({31'h0, panel_timing_active}, 32'h1);
    repeat (40) @(posedge sys_clk);
    cmp_n(tc[0] + tc[1], 0);
    $display("test reset done");
    // status, unmapped and no-lane writes are dropped
    wr(`DCS_STATUS_OFS, 32'hffffffff);
    wr(5'h14, 32'hffffffff);
    bus(1'b1, `DCS_PTC_OFS, 32'h1, 4'h0);
    rdc(`DCS_STATUS_OFS, 32'h0);
    rdc(5'h14, 32'h0);
    rdc(`DCS_PTC_OFS, 32'h0);
    $display("test refused done");
    wr(`DCS_SRC_SEL_OFS, 32'h2);
    wr(`DCS_DIV_EN_OFS, 32'hbd);
    rdc(`DCS_DIV_EN_OFS, 32'hbd);
    tk(0, 2);
    tk(1, 2);
    rdc(`DCS_STATUS_OFS, 32'hb);
    chk_gap(0, 18);
    chk_gap(1, 8);
    wr(`DCS_SRC_SEL_OFS, 32'h1);
    tk(0, 2);
    tk(1, 2);
    rdc(`DCS_STATUS_OFS, 32'h7);
    chk_gap(0, 12);
    chk_gap(1, 12);
    $display("test source done");
    wr(`DCS_SRC_SEL_OFS, 32'h0);
    for (int d = 0; d < 8; d++) begin
      wr(`DCS_DIV_EN_OFS, 32'h88 | d);
      tk(0, 2);
      chk_gap(0, (d + 1) * 3);
    end
    chk_gap(1, 3);
    $display("test divider done");
    // shrink divisor mid-period: old period must finish whole
    tk(0, 1);
    t0 = $time;
    repeat (4) @(posedge sys_clk);
    wr(`DCS_DIV_EN_OFS, 32'h08);
    tk(0, 1);
    cmp_n(int'(($time - t0) / 10), 24);
    chk_gap(0, 3);
    $display("test glitch done");
    wr(`DCS_DIV_EN_OFS, 32'h88);
    wr(`DCS_PIX_DIV_OFS, 32'h0402);
    rdc(`DCS_PIX_DIV_OFS, 32'h0402);
    tk(0, 30);
    tk(1, 30);
    cmp_n(pg[0], 3);
    cmp_n(pg[1], 5);
    $display("test pixel done");
    wr(`DCS_DIV_EN_OFS, 32'h0);
    repeat (30) @(posedge sys_clk);
    g = tc[0] + tc[1];
    repeat (60) @(posedge sys_clk);
    cmp_n(tc[0] + tc[1], g);
    rdc(`DCS_STATUS_OFS, 32'h0);
    $display("test disable done");
    cmp_w({8'h0, panel_rgb}, {8'h0, rgb0});
    wr(`DCS_PTC_OFS, 32'h1);
    // path flag is registered one edge after the write lands
    @(posedge sys_clk);
    cmp_w({31'h0, panel_timing_active}, 32'h0);
    wr(`DCS_PTC_OFS, 32'h3);
    repeat (2) @(posedge sys_clk);
    cmp_w({8'h0, panel_rgb}, {14'h0, rgb0[23:18], rgb0[15:10], rgb0[7:2]});
    wr(`DCS_PTC_OFS, 32'h0);
    @(posedge sys_clk);
    cmp_w({31'h0, panel_timing_active}, 32'h1);
    $display("test panel done");
    end_sim;
  end
endmodule // tb_dcs_top
